// ---- hw/cpu_status_flags_and_acc_store.sv ----
// Status byte, ALU flags and accumulator store path with Wishbone registers
// Functional notes
// - Status bits 7..5 hold the three-bit priority, 7 blocks user interrupts.
// - The four-bit level joins core control bit 3 above the field; bit 3 set blocks users.
// - The priority field ignores writes while interrupt control one bit 15 is set.
// - Status bit 4 is one while a repeat loop runs and zero otherwise.
// - Status bit 3 follows the sign of the last flag-affecting result.
// - Status bit 2 shows two's complement overflow of the last flag-affecting result, zero for logic results.
// - Status bit 1 is the zero flag, sticky under ADDC and SUBB, where only a later non-zero result clears it.
// - Status bit 0 shows carry-out from the result's top bit.
// - Plain store writes the truncated accumulator, rounded store the rounded one, both saturated only with write saturation on.
// - Multiply-accumulate writeback goes over the X bus and is always rounded.
// - With write saturation on, values clamp to 0x7fff or 0x8000 by the bit 39 sign.
// - With write saturation off, the store value passes unchanged.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module cpu_status_flags_and_acc_store #(
   parameter int XADDR_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   // Instruction side
   input wire status_store_pkg::instr_t instr_i,
   input wire logic repeat_active_i,
   // X bus store port
   output logic xbus_wr_o,
   output logic [XADDR_W-1:0] xbus_addr_o,
   output logic [15:0] xbus_data_o,
   // Status outputs
   output logic [7:0] status_word_o,
   output logic [3:0] cpu_priority_level_o,
   output logic user_irq_blocked_o,
   output logic irq_o
);

   // Elaboration check on the X bus address width
   if (XADDR_W < 1 || XADDR_W > 16)
   begin : g_bad_width
      $error("XADDR_W must lie between 1 and 16");
   end

   // The store path slices fixed positions out of the package widths
   if (status_store_pkg::ACC_SIGN != status_store_pkg::ACC_W - 1)
   begin : g_bad_sign
      $error("ACC_SIGN must be the top accumulator bit");
   end
   if (status_store_pkg::RND_W != status_store_pkg::ACC_W - 16)
   begin : g_bad_round
      $error("RND_W must cover the accumulator above the store word");
   end
   if (status_store_pkg::EV_W != 3)
   begin : g_bad_events
      $error("EV_W must match the three event sources");
   end
   if (status_store_pkg::SAT_POS != ~status_store_pkg::SAT_NEG)
   begin : g_bad_limits
      $error("SAT_POS and SAT_NEG must be the two 1.15 extremes");
   end

   // Complete state of the block
   typedef struct packed {
      logic [2:0] prio;
      logic prio_high;
      logic nest_dis;
      logic sat_en;
      logic loop_running_flag;
      logic neg;
      logic ovf;
      logic zero;
      logic carry;
      logic [status_store_pkg::EV_W-1:0] ev_sts;
      logic [status_store_pkg::EV_W-1:0] ev_msk;
      logic ack;
      logic [31:0] rdata;
      logic xwr;
      logic [XADDR_W-1:0] xaddr;
      logic [15:0] xdata;
      logic [15:0] last_store;
      logic [3:0] level;
      logic blocked;
      logic irq;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Rounding adder width, one bit per accumulator bit above the store word
   localparam int RND_W_L = status_store_pkg::RND_W;

   // ALU and store path intermediates
   logic [16:0] sum;
   logic [15:0] res;
   logic arith;
   logic sticky_z;
   logic ovf_now;
   logic [RND_W_L-1:0] rnd;
   logic [15:0] store_val;
   logic sat_hit;
   logic is_store;
   logic do_round;
   logic wr_access;
   logic rd_access;
   logic [2:0] prio_wr;
   logic [status_store_pkg::EV_W-1:0] ev_set;
   logic [31:0] rd_mux;
   logic [7:0] sw_byte;
   logic is_alu;

   // Arithmetic and logic result with carry and overflow
   always_comb
   begin
      sum = 17'h00000;
      arith = 1'b1;
      sticky_z = 1'b0;
      case (instr_i.op)
         status_store_pkg::OP_ADD:
            sum = {1'b0, instr_i.opa} + {1'b0, instr_i.opb};
         status_store_pkg::OP_ADDC:
         begin
            sum = {1'b0, instr_i.opa} + {1'b0, instr_i.opb} + {16'h0000, state_reg.carry};
            sticky_z = 1'b1;
         end
         status_store_pkg::OP_SUB:
            sum = {1'b0, instr_i.opa} + {1'b0, ~instr_i.opb} + 17'h00001;
         status_store_pkg::OP_SUBB:
         begin
            sum = {1'b0, instr_i.opa} + {1'b0, ~instr_i.opb} + {16'h0000, state_reg.carry};
            sticky_z = 1'b1;
         end
         status_store_pkg::OP_AND:
         begin
            sum = {1'b0, instr_i.opa & instr_i.opb};
            arith = 1'b0;
         end
         status_store_pkg::OP_IOR:
         begin
            sum = {1'b0, instr_i.opa | instr_i.opb};
            arith = 1'b0;
         end
         status_store_pkg::OP_XOR:
         begin
            sum = {1'b0, instr_i.opa ^ instr_i.opb};
            arith = 1'b0;
         end
         default:
            arith = 1'b0;
      endcase
      res = sum[15:0];
   end

   // Sign change that the operands cannot explain
   assign ovf_now = arith & (instr_i.opa[15] == (instr_i.opb[15] ^
      (instr_i.op inside {status_store_pkg::OP_SUB, status_store_pkg::OP_SUBB})))
      & (res[15] != instr_i.opa[15]);

   // Only the ALU codes may move the flags; stores and unknown codes leave them
   assign is_alu = instr_i.valid & (instr_i.op inside {status_store_pkg::OP_ADD,
      status_store_pkg::OP_ADDC, status_store_pkg::OP_SUB, status_store_pkg::OP_SUBB,
      status_store_pkg::OP_AND, status_store_pkg::OP_IOR, status_store_pkg::OP_XOR});

   // Store path: truncate or round, then optional write saturation
   always_comb
   begin
      is_store = instr_i.valid & (instr_i.op inside {status_store_pkg::OP_STORE_ACC,
         status_store_pkg::OP_STORE_ACC_RND, status_store_pkg::OP_MULT_ACC_WB});
      do_round = instr_i.op != status_store_pkg::OP_STORE_ACC;
      rnd = instr_i.acc[39:16] + {23'h000000, do_round & instr_i.acc[15]};
      sat_hit = 1'b0;
      store_val = rnd[15:0];
      if (state_reg.sat_en)
      begin
         if (!instr_i.acc[status_store_pkg::ACC_SIGN] && rnd[23:15] != 9'h000)
         begin
            store_val = status_store_pkg::SAT_POS;
            sat_hit = 1'b1;
         end
         else if (instr_i.acc[status_store_pkg::ACC_SIGN] && rnd[23:15] != 9'h1ff)
         begin
            store_val = status_store_pkg::SAT_NEG;
            sat_hit = 1'b1;
         end
      end
   end

   // Wishbone access qualifiers
   // Ack low gate keeps a strobe held at the ack edge from counting twice
   assign wr_access = wb_cyc_i & wb_stb_i & wb_we_i & ~state_reg.ack;
   assign rd_access = wb_cyc_i & wb_stb_i & ~wb_we_i & ~state_reg.ack;

   // Status word as software sees it
   assign sw_byte = {state_reg.prio, state_reg.loop_running_flag, state_reg.neg,
      state_reg.ovf, state_reg.zero, state_reg.carry};

   // Read data multiplexer, unmapped reads as zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (wb_adr_i)
         status_store_pkg::OFS_STATUS_WORD:
            rd_mux = {24'h000000, sw_byte};
         status_store_pkg::OFS_CORE_CONTROL:
         begin
            rd_mux[status_store_pkg::CC_PRIO_HIGH] = state_reg.prio_high;
            rd_mux[status_store_pkg::CC_SAT_EN] = state_reg.sat_en;
         end
         status_store_pkg::OFS_INT_CONTROL_ONE:
            rd_mux[status_store_pkg::IC1_NEST_DIS] = state_reg.nest_dis;
         status_store_pkg::OFS_EVENT_STATUS:
            rd_mux = {29'h00000000, state_reg.ev_sts};
         status_store_pkg::OFS_EVENT_MASK:
            rd_mux = {29'h00000000, state_reg.ev_msk};
         status_store_pkg::OFS_LAST_STORE:
            rd_mux = {16'h0000, state_reg.last_store};
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // Next state of the whole block
   always_comb
   begin
      state_next = state_reg;
      ev_set = '0;
      prio_wr = wb_dat_i[7:5];
      state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
      state_next.rdata = rd_access ? rd_mux : state_reg.rdata;
      state_next.xwr = 1'b0;

      // Software writes, hardware updates below take precedence
      if (wr_access)
      begin
         case (wb_adr_i)
            status_store_pkg::OFS_STATUS_WORD:
               if (wb_sel_i[0])
               begin
                  if (!state_reg.nest_dis)
                     state_next.prio = prio_wr;
                  else if (prio_wr != state_reg.prio)
                     ev_set[status_store_pkg::EV_PRIO_REFUSED] = 1'b1;
                  state_next.neg = wb_dat_i[status_store_pkg::SW_NEG];
                  state_next.ovf = wb_dat_i[status_store_pkg::SW_OVF];
                  state_next.zero = wb_dat_i[status_store_pkg::SW_ZERO];
                  state_next.carry = wb_dat_i[status_store_pkg::SW_CARRY];
               end
            status_store_pkg::OFS_CORE_CONTROL:
               if (wb_sel_i[0])
               begin
                  state_next.prio_high = wb_dat_i[status_store_pkg::CC_PRIO_HIGH];
                  state_next.sat_en = wb_dat_i[status_store_pkg::CC_SAT_EN];
               end
            status_store_pkg::OFS_INT_CONTROL_ONE:
               if (wb_sel_i[1])
                  state_next.nest_dis = wb_dat_i[status_store_pkg::IC1_NEST_DIS];
            status_store_pkg::OFS_EVENT_STATUS:
               if (wb_sel_i[0])
                  state_next.ev_sts = state_reg.ev_sts & ~wb_dat_i[2:0];
            status_store_pkg::OFS_EVENT_MASK:
               if (wb_sel_i[0])
                  state_next.ev_msk = wb_dat_i[2:0];
            default:
               state_next.ev_msk = state_reg.ev_msk;
         endcase
      end

      // Repeat loop indicator follows the loop controller
      state_next.loop_running_flag = repeat_active_i;

      // Flag updates only for flags the instruction affects
      // Stores and undecoded codes never reach the flags
      if (is_alu)
      begin
         if (instr_i.upd.neg)
            state_next.neg = res[15];
         if (instr_i.upd.ovf)
         begin
            state_next.ovf = ovf_now;
            ev_set[status_store_pkg::EV_OVF] = ovf_now;
         end
         if (instr_i.upd.zero)
            state_next.zero = sticky_z ? (state_reg.zero & (res == 16'h0000))
               : (res == 16'h0000);
         if (instr_i.upd.carry)
            state_next.carry = sum[16];
      end

      // Accumulator store over the X bus
      if (is_store)
      begin
         state_next.xwr = 1'b1;
         state_next.xaddr = instr_i.addr[XADDR_W-1:0];
         state_next.xdata = store_val;
         state_next.last_store = store_val;
         ev_set[status_store_pkg::EV_SAT] = sat_hit;
      end

      // Sticky events, a new event wins over a clear
      state_next.ev_sts = state_next.ev_sts | ev_set;
      state_next.irq = |(state_next.ev_sts & state_next.ev_msk);

      // Effective four-bit level and user interrupt blocking
      state_next.level = {state_next.prio_high, state_next.prio};
      state_next.blocked = state_next.prio_high | (state_next.prio == 3'h7);
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
         state_reg.prio <= status_store_pkg::PRIO_RESET;
         state_reg.ev_sts <= status_store_pkg::EV_RESET;
      end
      else
         state_reg <= state_next;
   end

   // Outputs straight from the state register
   assign wb_ack_o = state_reg.ack;
   assign wb_dat_o = state_reg.rdata;
   assign xbus_wr_o = state_reg.xwr;
   assign xbus_addr_o = state_reg.xaddr;
   assign xbus_data_o = state_reg.xdata;
   assign status_word_o = {state_reg.prio, state_reg.loop_running_flag, state_reg.neg,
      state_reg.ovf, state_reg.zero, state_reg.carry};
   assign cpu_priority_level_o = state_reg.level;
   assign user_irq_blocked_o = state_reg.blocked;
   assign irq_o = state_reg.irq;

endmodule

// ---- hw/status_store_pkg.sv ----
// Package with register map, field positions, opcodes and carrier types
package status_store_pkg;

   // Wishbone register byte offsets
   localparam logic [7:0] OFS_STATUS_WORD = 8'h00;
   localparam logic [7:0] OFS_CORE_CONTROL = 8'h04;
   localparam logic [7:0] OFS_INT_CONTROL_ONE = 8'h08;
   localparam logic [7:0] OFS_EVENT_STATUS = 8'h0c;
   localparam logic [7:0] OFS_EVENT_MASK = 8'h10;
   localparam logic [7:0] OFS_LAST_STORE = 8'h14;

   // Status word field positions
   localparam int SW_PRIO_LSB = 5;
   localparam int SW_LOOP = 4;
   localparam int SW_NEG = 3;
   localparam int SW_OVF = 2;
   localparam int SW_ZERO = 1;
   localparam int SW_CARRY = 0;

   // Core control and interrupt control one field positions
   localparam int CC_PRIO_HIGH = 3;
   localparam int CC_SAT_EN = 5;
   localparam int IC1_NEST_DIS = 15;

   // Event bits
   localparam int EV_OVF = 0;
   localparam int EV_SAT = 1;
   localparam int EV_PRIO_REFUSED = 2;
   localparam int EV_W = 3;

   // Reset values
   localparam logic [2:0] PRIO_RESET = 3'h0;
   localparam logic [EV_W-1:0] EV_RESET = 3'h0;

   // Accumulator and store widths, saturation limits
   localparam int ACC_W = 40;
   localparam int ACC_SIGN = 39;
   localparam int RND_W = 24;
   localparam logic [15:0] SAT_POS = 16'h7fff;
   localparam logic [15:0] SAT_NEG = 16'h8000;

   // Instruction codes presented by the decoder
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_ADDC = 4'h2,
      OP_SUB = 4'h3,
      OP_SUBB = 4'h4,
      OP_AND = 4'h5,
      OP_IOR = 4'h6,
      OP_XOR = 4'h7,
      OP_STORE_ACC = 4'h8,
      OP_STORE_ACC_RND = 4'h9,
      OP_MULT_ACC_WB = 4'ha
   } op_t;

   // Which ALU flags the instruction is defined to affect
   typedef struct packed {
      logic neg;
      logic ovf;
      logic zero;
      logic carry;
   } flag_upd_t;

   // One instruction issue
   typedef struct packed {
      logic valid;
      op_t op;
      flag_upd_t upd;
      logic [15:0] opa;
      logic [15:0] opb;
      logic [ACC_W-1:0] acc;
      logic [15:0] addr;
   } instr_t;

endpackage

// ---- verification/xdata_memory_model.sv ----
// Data memory model on the far side of the X bus store port
`timescale 1ns/10ps
module xdata_memory_model (
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] data_i
);
   logic [15:0] mem [0:255];
   // Capture one word on each store strobe
   always_ff @(posedge clk_i)
   begin
      if (wr_i)
         mem[addr_i[7:0]] <= data_i;
   end
endmodule

// ---- verification/status_store_properties.sv ----
// Concurrent checks on the status byte and store port
`timescale 1ns/10ps
module status_store_checker #(
   parameter int XADDR_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire status_store_pkg::instr_t instr_i,
   input wire logic repeat_active_i,
   input wire logic xbus_wr_o,
   input wire logic [XADDR_W-1:0] xbus_addr_o,
   input wire logic [15:0] xbus_data_o,
   input wire logic [7:0] status_word_o,
   input wire logic [3:0] cpu_priority_level_o,
   input wire logic user_irq_blocked_o,
   input wire logic irq_o
);
   logic [16:0] sum;
   logic [23:0] rnd;
   logic add_all, add_ovf, addc_z, st_tr, st_rn;
   logic [15:0] tr_val;
   // Expected adder, rounding and store qualifiers
   assign sum = {1'b0, instr_i.opa} + {1'b0, instr_i.opb};
   assign add_ovf = instr_i.opa[15] == instr_i.opb[15] && sum[15] != instr_i.opa[15];
   assign addc_z = status_word_o[1] && (sum[15:0] + {15'h0, status_word_o[0]}) == 16'h0;
   assign add_all = instr_i.valid && instr_i.op == status_store_pkg::OP_ADD
      && instr_i.upd == 4'hf;
   assign rnd = instr_i.acc[39:16] + {23'h0, instr_i.acc[15]};
   assign tr_val = instr_i.acc[31:16];
   assign st_tr = instr_i.valid && instr_i.op == status_store_pkg::OP_STORE_ACC
      && (&instr_i.acc[39:31] || ~|instr_i.acc[39:31]);
   assign st_rn = instr_i.valid && (&rnd[23:15] || ~|rnd[23:15])
      && (instr_i.op == status_store_pkg::OP_STORE_ACC_RND
      || instr_i.op == status_store_pkg::OP_MULT_ACC_WB);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_blocked_level: assert property (user_irq_blocked_o ==
      (cpu_priority_level_o[3] || cpu_priority_level_o[2:0] == 3'h7))
      else $error("blocked flag disagrees with level");
   a_level_join: assert property (cpu_priority_level_o[2:0] == status_word_o[7:5])
      else $error("level low bits differ from status field");
   a_loop_track: assert property (!$past(rst_i) |->
      status_word_o[4] == $past(repeat_active_i)) else $error("loop flag wrong");
   a_neg_sign: assert property (add_all |=> status_word_o[3] == $past(sum[15]))
      else $error("negative flag wrong");
   a_ovf_sign: assert property (add_all |=> status_word_o[2] == $past(add_ovf))
      else $error("overflow flag wrong");
   a_zero_sticky: assert property (instr_i.valid && instr_i.upd.zero
      && instr_i.op == status_store_pkg::OP_ADDC |=> status_word_o[1] == $past(addc_z))
      else $error("sticky zero wrong");
   a_carry_out: assert property (add_all |=> status_word_o[0] == $past(sum[16]))
      else $error("carry flag wrong");
   a_flag_hold: assert property (!instr_i.valid && !(wb_cyc_i && wb_we_i)
      |=> $stable(status_word_o[3:0])) else $error("flags moved without cause");
   a_store_trunc: assert property (st_tr |=> xbus_wr_o &&
      xbus_data_o == $past(tr_val)) else $error("truncated store wrong");
   a_store_round: assert property (st_rn |=> xbus_wr_o &&
      xbus_data_o == $past(rnd[15:0])) else $error("rounded store wrong");
   a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not one cycle");
endmodule
bind cpu_status_flags_and_acc_store status_store_checker #(.XADDR_W(XADDR_W))
   i_status_store_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_i(instr_i),
   .repeat_active_i(repeat_active_i), .xbus_wr_o(xbus_wr_o), .xbus_addr_o(xbus_addr_o),
   .xbus_data_o(xbus_data_o), .status_word_o(status_word_o), .irq_o(irq_o),
   .cpu_priority_level_o(cpu_priority_level_o), .user_irq_blocked_o(user_irq_blocked_o));

// ---- verification/cpu_status_flags_and_acc_store_tb_top.sv ----
// Self-checking testbench for the status byte and store path
`timescale 1ns/10ps
module cpu_status_flags_and_acc_store_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_ack_o, xbus_wr_o, user_irq_blocked_o, irq_o;
   status_store_pkg::instr_t instr_i = '0;
   logic repeat_active_i = 1'b0;
   logic [15:0] xbus_addr_o, xbus_data_o;
   logic [7:0] status_word_o;
   logic [3:0] cpu_priority_level_o;
   int failures = 0;
   int check_count = 0;
   // Core clock, 10 ns period
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   cpu_status_flags_and_acc_store i_cpu_status_flags_and_acc_store (.clk_i(clk_i),
      .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .instr_i(instr_i), .repeat_active_i(repeat_active_i),
      .xbus_wr_o(xbus_wr_o), .xbus_addr_o(xbus_addr_o), .xbus_data_o(xbus_data_o),
      .status_word_o(status_word_o), .cpu_priority_level_o(cpu_priority_level_o),
      .user_irq_blocked_o(user_irq_blocked_o), .irq_o(irq_o));
   xdata_memory_model i_xdata_memory_model (.clk_i(clk_i), .wr_i(xbus_wr_o),
      .addr_i(xbus_addr_o), .data_i(xbus_data_o));
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   // One classic Wishbone cycle, then one settling cycle
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'h3;
      do
      begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge clk_i);
      #1;
   endtask
   // Issue one instruction and let its result land
   task automatic op(input status_store_pkg::op_t o, input logic [3:0] u,
         input logic [15:0] a, input logic [15:0] b, input logic [39:0] acc);
      @(posedge clk_i);
      instr_i <= '{1'b1, o, u, a, b, acc, a};
      @(posedge clk_i);
      instr_i.valid <= 1'b0;
      #1;
   endtask
   // Store and compare port and memory
   task automatic st(input status_store_pkg::op_t o, input logic [15:0] a,
         input logic [39:0] acc, input logic [15:0] e);
      op(o, 4'h0, a, 16'h0, acc);
      chk("store strobe", 1, xbus_wr_o);
      chk("store addr", a, xbus_addr_o);
      chk("store data", e, xbus_data_o);
      @(posedge clk_i);
      #1;
      chk("memory word", e, i_xdata_memory_model.mem[a[7:0]]);
   endtask
   task automatic t_reset();
      chk("status out", 0, status_word_o);
      chk("level out", 0, cpu_priority_level_o);
      wb(status_store_pkg::OFS_STATUS_WORD, 1'b0, 0);
      chk("status reg", 0, rd);
      $display("test reset done");
   endtask
   task automatic t_flags();
      op(status_store_pkg::OP_ADD, 4'hf, 16'h7fff, 16'h0001, 0);
      chk("neg ovf", 8'h0c, status_word_o);
      op(status_store_pkg::OP_ADD, 4'hf, 16'hffff, 16'h0001, 0);
      chk("zero carry", 8'h03, status_word_o);
      op(status_store_pkg::OP_ADDC, 4'hf, 16'hffff, 16'h0000, 0);
      chk("zero kept", 8'h03, status_word_o);
      op(status_store_pkg::OP_ADDC, 4'h2, 16'h0001, 16'h0001, 0);
      chk("zero cleared", 8'h01, status_word_o);
      op(status_store_pkg::OP_ADD, 4'h8, 16'h8000, 16'h0001, 0);
      chk("neg only", 8'h09, status_word_o);
      op(status_store_pkg::OP_SUB, 4'hf, 16'h0003, 16'h0005, 0);
      chk("borrow", 8'h08, status_word_o);
      op(status_store_pkg::OP_SUBB, 4'hf, 16'h0005, 16'h0003, 0);
      chk("borrow in", 8'h01, status_word_o);
      op(status_store_pkg::OP_AND, 4'ha, 16'hf0f0, 16'h0f0f, 0);
      chk("and zero", 8'h03, status_word_o);
      op(status_store_pkg::OP_XOR, 4'ha, 16'h8000, 16'h0001, 0);
      chk("xor neg", 8'h09, status_word_o);
      op(status_store_pkg::OP_IOR, 4'ha, 16'h0000, 16'h0000, 0);
      chk("ior zero", 8'h03, status_word_o);
      $display("test flags done");
   endtask
   task automatic t_loop();
      @(posedge clk_i);
      repeat_active_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk("loop on", 1, status_word_o[4]);
      @(posedge clk_i);
      repeat_active_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk("loop off", 0, status_word_o[4]);
      $display("test loop done");
   endtask
   task automatic t_prio();
      wb(status_store_pkg::OFS_STATUS_WORD, 1'b1, 32'he0);
      chk("prio seven", 5'h17, {user_irq_blocked_o, cpu_priority_level_o});
      wb(status_store_pkg::OFS_CORE_CONTROL, 1'b1, 32'h08);
      chk("level high", 5'h1f, {user_irq_blocked_o, cpu_priority_level_o});
      wb(status_store_pkg::OFS_CORE_CONTROL, 1'b1, 32'h0);
      wb(status_store_pkg::OFS_STATUS_WORD, 1'b1, 32'h20);
      chk("prio one", 5'h01, {user_irq_blocked_o, cpu_priority_level_o});
      wb(status_store_pkg::OFS_EVENT_MASK, 1'b1, 32'h4);
      wb(status_store_pkg::OFS_INT_CONTROL_ONE, 1'b1, 32'h8000);
      wb(status_store_pkg::OFS_STATUS_WORD, 1'b1, 32'h80);
      chk("prio locked", 3'h1, status_word_o[7:5]);
      chk("irq raised", 1, irq_o);
      wb(status_store_pkg::OFS_EVENT_MASK, 1'b1, 32'h0);
      chk("irq masked", 0, irq_o);
      wb(status_store_pkg::OFS_EVENT_MASK, 1'b1, 32'h4);
      wb(status_store_pkg::OFS_EVENT_STATUS, 1'b1, 32'h4);
      chk("irq cleared", 0, irq_o);
      wb(status_store_pkg::OFS_INT_CONTROL_ONE, 1'b1, 32'h0);
      wb(status_store_pkg::OFS_STATUS_WORD, 1'b1, 32'h0);
      wb(8'h18, 1'b1, 32'hffff);
      wb(8'h18, 1'b0, 0);
      chk("unmapped read", 0, rd);
      $display("test priority done");
   endtask
   task automatic t_store();
      st(status_store_pkg::OP_STORE_ACC, 16'h40, 40'h0012348000, 16'h1234);
      st(status_store_pkg::OP_STORE_ACC_RND, 16'h41, 40'h0012348000, 16'h1235);
      st(status_store_pkg::OP_STORE_ACC, 16'h42, 40'h0100000000, 16'h0000);
      wb(status_store_pkg::OFS_CORE_CONTROL, 1'b1, 32'h20);
      st(status_store_pkg::OP_STORE_ACC, 16'h43, 40'h0100000000, 16'h7fff);
      st(status_store_pkg::OP_STORE_ACC_RND, 16'h44, 40'hff00000000, 16'h8000);
      st(status_store_pkg::OP_MULT_ACC_WB, 16'h45, 40'h0000018000, 16'h0002);
      wb(status_store_pkg::OFS_EVENT_STATUS, 1'b0, 0);
      chk("sat event", 1, rd[status_store_pkg::EV_SAT]);
      $display("test store done");
   endtask
   task automatic t_rerst();
      op(status_store_pkg::OP_ADD, 4'hf, 16'h7fff, 16'h0001, 0);
      wb(status_store_pkg::OFS_CORE_CONTROL, 1'b1, 32'h08);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("status after reset", 0, status_word_o);
      chk("level after reset", 0, cpu_priority_level_o);
      $display("test mid-run reset done");
   endtask
   // Print the counts and the verdict, then stop
   task automatic give_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial
   begin
      #100us;
      failures++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      t_reset();
      t_flags();
      t_loop();
      t_prio();
      t_store();
      t_rerst();
      give_verdict();
   end
endmodule
